// File: logic/spp_params.svh
// constants for the sequential port pointer control block
// Functional notes
// - pointer_load_n low at a clock edge loads the presented address into pointer.
// - count_enable_n high at a clock edge holds the pointer.
// - no increment in the cycle right after a pointer load.
// - a buffer start jump loads that buffer's start address into the pointer.
// - a start jump does not suppress counting in the following cycle.
// - chip enable low with read high reads the pointed word into the two-entry read buffer.
// - chip enable low with read_write low writes input data at the pointer.
// - registered write state keeps outputs disabled whatever output enable says.
// - writes with counting held off overwrite the same address again.
// - reset forces the internal read/write state to write.
// - the first counted access after reset targets address zero.
// - the second counted write after reset goes to address one.
// - release command on flow bit 4 at address 100 arms the halted pointer, which resumes only if count_enable_n is low the next cycle.
`ifndef SPP_PARAMS_SVH
`define SPP_PARAMS_SVH
`define SPP_ADDR_W        13
`define SPP_DATA_W        16
`define SPP_DEPTH         8192
`define SPP_CMD_A_W       3
`define SPP_CMD_FLOW      3'h4
`define SPP_FLOW_REL_BIT  4
`define SPP_RESET_PTR     13'h0000
`endif

// File: logic/spp_pkg.sv
// types of the sequential port pointer control block
package spp_pkg;
    typedef struct packed {
        logic        load_n;
        logic        jump1_n;
        logic        jump2_n;
        logic        count_n;
        logic        ce_n;
        logic        rw;
        logic        oe_n;
        logic [12:0] addr;
        logic [15:0] data;
    } spp_seq_in_t;
    typedef struct packed {
        logic        sel_n;
        logic        ce_n;
        logic        wr_n;
        logic [2:0]  addr;
        logic [15:0] data;
    } spp_cmd_t;
    typedef enum logic [1:0] {
        SPP_RUN    = 2'b00,
        SPP_HALTED = 2'b01,
        SPP_ARMED  = 2'b11
    } spp_flow_t;
endpackage

// File: logic/spp_core.sv
// sequential port pointer, memory, output gating and flow release
`include "spp_params.svh"
module spp_core
    import spp_pkg::*;
(
    // clock and reset
    input  wire logic               clk,
    input  wire logic               rst,
    // sequential port pins, asynchronous to clk
    input  wire spp_seq_in_t        seq_pin,
    // random port command access, asynchronous to clk
    input  wire spp_cmd_t           cmd_pin,
    // buffer layout
    input  wire logic [12:0]        buf1_start,
    input  wire logic [12:0]        buf2_start,
    input  wire logic [12:0]        buf1_end,
    input  wire logic [12:0]        buf2_end,
    input  wire logic               stop_at_end,
    // sequential data out, valid/ready toward receiver
    output logic [15:0]             seq_data_out,
    output logic                    seq_data_oe,
    output logic                    rd_valid,
    input  wire logic               rd_ready,
    // status
    output logic [12:0]             pointer,
    output logic                    halted,
    output logic                    end_of_buffer_flag,
    output logic                    stall
);
    // =========================================
    // input synchronisers
    // =========================================
    spp_seq_in_t seq_m_q, seq_s_q;
    spp_cmd_t    cmd_m_q, cmd_s_q, cmd_p_q;
    always_ff @(posedge clk) begin
        seq_m_q <= seq_pin;
        seq_s_q <= seq_m_q;
        cmd_m_q <= cmd_pin;
        cmd_s_q <= cmd_m_q;
        cmd_p_q <= cmd_s_q;
    end

    function automatic logic is_flow_rel(spp_cmd_t c);
        return !c.sel_n && c.ce_n && !c.wr_n
            && c.addr == `SPP_CMD_FLOW && !c.data[`SPP_FLOW_REL_BIT];
    endfunction

    // one-cycle release pulse on the command write's falling strobe
    logic internal_release_pulse;
    assign internal_release_pulse = is_flow_rel(cmd_s_q)
                                  && !is_flow_rel(cmd_p_q);

    // =========================================
    // pointer and flow state
    // =========================================
    logic [12:0] ptr_q, ptr_d;
    logic        supp_q;
    spp_flow_t   flow_q, flow_d;
    logic        at_end, can_count, ce_act, is_wr, is_rd;
    logic [1:0]  cnt_q;

    // stall only when both entries are taken and the receiver holds off
    assign stall  = is_rd && cnt_q == 2'h2 && !rd_ready;
    assign ce_act = !seq_s_q.ce_n && !stall;
    assign is_wr  = ce_act && !seq_s_q.rw;
    assign is_rd  = !seq_s_q.ce_n && seq_s_q.rw;
    assign at_end = stop_at_end
                 && (ptr_q == buf1_end || ptr_q == buf2_end);
    assign can_count = !seq_s_q.count_n && !supp_q
                    && flow_q != SPP_HALTED && !stall;

    always_comb begin
        ptr_d = ptr_q;
        if (!seq_s_q.load_n)
            ptr_d = seq_s_q.addr;
        else if (!seq_s_q.jump1_n)
            ptr_d = buf1_start;
        else if (!seq_s_q.jump2_n)
            ptr_d = buf2_start;
        else if (can_count && !(at_end && flow_q == SPP_RUN))
            ptr_d = 13'(ptr_q + 13'h0001);
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            ptr_q  <= `SPP_RESET_PTR;
            supp_q <= 1'b0;
        end else begin
            ptr_q  <= ptr_d;
            supp_q <= !seq_s_q.load_n;
        end
    end

    always_comb begin
        flow_d = flow_q;
        unique case (flow_q)
            SPP_RUN:
                if (can_count && at_end)
                    flow_d = SPP_HALTED;
            SPP_HALTED:
                if (internal_release_pulse)
                    flow_d = SPP_ARMED;
            SPP_ARMED:
                flow_d = seq_s_q.count_n ? SPP_HALTED : SPP_RUN;
            default:
                flow_d = SPP_RUN;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst)
            flow_q <= SPP_RUN;
        else
            flow_q <= flow_d;
    end

    always_ff @(posedge clk) begin
        if (rst)
            end_of_buffer_flag <= 1'b0;
        else if (flow_d == SPP_HALTED && flow_q == SPP_RUN)
            end_of_buffer_flag <= 1'b1;
        else if (internal_release_pulse)
            end_of_buffer_flag <= 1'b0;
    end

    assign pointer = ptr_q;
    assign halted  = flow_q == SPP_HALTED;

    // =========================================
    // memory array
    // =========================================
    logic [15:0] mem_q [`SPP_DEPTH];
    always_ff @(posedge clk) begin
        if (is_wr)
            mem_q[ptr_q] <= seq_s_q.data;
    end

    // =========================================
    // read/write state and output gating
    // =========================================
    logic rw_q;
    always_ff @(posedge clk) begin
        if (rst)
            rw_q <= 1'b0;
        else if (!seq_s_q.ce_n)
            rw_q <= seq_s_q.rw;
    end
    assign seq_data_oe = rw_q && !seq_s_q.oe_n;

    // =========================================
    // two-entry read buffer
    // =========================================
    logic [15:0] buf_q [2];
    logic        wp_q, rp_q;
    logic        push, pop;
    assign push     = is_rd && !stall;
    assign pop      = rd_valid && rd_ready;
    assign rd_valid = cnt_q != 2'h0;

    always_ff @(posedge clk) begin
        if (rst) begin
            wp_q  <= 1'b0;
            rp_q  <= 1'b0;
            cnt_q <= 2'h0;
        end else begin
            if (push) begin
                buf_q[wp_q] <= mem_q[ptr_q];
                wp_q <= !wp_q;
            end
            if (pop)
                rp_q <= !rp_q;
            cnt_q <= 2'(cnt_q + {1'b0, push} - {1'b0, pop});
        end
    end

    always_ff @(posedge clk) begin
        if (rst)
            seq_data_out <= 16'h0000;
        else if (pop)
            seq_data_out <= buf_q[rp_q];
    end

    // =========================================
    // checks on the pointer
    // =========================================
    load_takes_a: assert property (@(posedge clk) disable iff (rst)
        !seq_s_q.load_n |=> ptr_q == $past(seq_s_q.addr))
        else $error("pointer load missed");

    hold_when_off_a: assert property (@(posedge clk) disable iff (rst)
        seq_s_q.count_n && seq_s_q.load_n && seq_s_q.jump1_n
        && seq_s_q.jump2_n |=> $stable(ptr_q))
        else $error("pointer moved with count off");

    no_inc_after_a: assert property (@(posedge clk) disable iff (rst)
        !seq_s_q.load_n ##1 (seq_s_q.load_n && seq_s_q.jump1_n
        && seq_s_q.jump2_n) |=> $stable(ptr_q))
        else $error("pointer advanced after load");

    supp_set_a: assert property (@(posedge clk) disable iff (rst)
        !seq_s_q.load_n |=> supp_q)
        else $error("count not suppressed after load");

    jump_one_a: assert property (@(posedge clk) disable iff (rst)
        seq_s_q.load_n && !seq_s_q.jump1_n |=> ptr_q == $past(buf1_start))
        else $error("buffer one jump missed");

    jump_two_a: assert property (@(posedge clk) disable iff (rst)
        seq_s_q.load_n && seq_s_q.jump1_n && !seq_s_q.jump2_n
        |=> ptr_q == $past(buf2_start))
        else $error("buffer two jump missed");

    jump_free_a: assert property (@(posedge clk) disable iff (rst)
        seq_s_q.load_n && (!seq_s_q.jump1_n || !seq_s_q.jump2_n)
        |=> !supp_q)
        else $error("count suppressed after jump");

    step_one_a: assert property (@(posedge clk) disable iff (rst)
        can_count && seq_s_q.load_n && seq_s_q.jump1_n && seq_s_q.jump2_n
        && !at_end |=> ptr_q == 13'($past(ptr_q) + 13'h0001))
        else $error("pointer step wrong");

    stall_hold_a: assert property (@(posedge clk) disable iff (rst)
        stall && seq_s_q.load_n && seq_s_q.jump1_n && seq_s_q.jump2_n
        |=> $stable(ptr_q))
        else $error("pointer moved during stall");

    reset_ptr_a: assert property (@(posedge clk)
        rst |=> ptr_q == `SPP_RESET_PTR)
        else $error("pointer not cleared by reset");

    // =========================================
    // checks on flow control
    // =========================================
    release_a: assert property (@(posedge clk) disable iff (rst)
        flow_q == SPP_HALTED && internal_release_pulse
        |=> flow_q == SPP_ARMED)
        else $error("release ignored");

    armed_a: assert property (@(posedge clk) disable iff (rst)
        flow_q == SPP_ARMED && seq_s_q.count_n |=> flow_q == SPP_HALTED)
        else $error("halt not kept");

    armed_run_a: assert property (@(posedge clk) disable iff (rst)
        flow_q == SPP_ARMED && !seq_s_q.count_n |=> flow_q == SPP_RUN)
        else $error("armed pointer did not resume");

    halt_stay_a: assert property (@(posedge clk) disable iff (rst)
        flow_q == SPP_HALTED && !internal_release_pulse
        |=> flow_q == SPP_HALTED)
        else $error("halt left without release");

    halt_ptr_a: assert property (@(posedge clk) disable iff (rst)
        flow_q == SPP_HALTED && seq_s_q.load_n && seq_s_q.jump1_n
        && seq_s_q.jump2_n |=> $stable(ptr_q))
        else $error("pointer moved while halted");

    flag_clear_a: assert property (@(posedge clk) disable iff (rst)
        flow_q == SPP_HALTED && internal_release_pulse
        |=> !end_of_buffer_flag)
        else $error("end flag not cleared");

    flag_set_a: assert property (@(posedge clk) disable iff (rst)
        flow_q == SPP_RUN && flow_d == SPP_HALTED |=> end_of_buffer_flag)
        else $error("end flag not set");

    pulse_once_a: assert property (@(posedge clk) disable iff (rst)
        internal_release_pulse |=> !internal_release_pulse)
        else $error("release pulse too long");

    // =========================================
    // checks on the data path
    // =========================================
    rw_reset_a: assert property (@(posedge clk)
        rst |=> !seq_data_oe)
        else $error("outputs on after reset");

    out_gate_a: assert property (@(posedge clk) disable iff (rst)
        !rw_q |-> !seq_data_oe)
        else $error("output on in write state");

    wr_state_a: assert property (@(posedge clk) disable iff (rst)
        !seq_s_q.ce_n && !seq_s_q.rw |=> !seq_data_oe)
        else $error("output on after write");

    rd_state_a: assert property (@(posedge clk) disable iff (rst)
        !seq_s_q.ce_n && seq_s_q.rw |=> rw_q)
        else $error("read state not taken");

    rw_keep_a: assert property (@(posedge clk) disable iff (rst)
        seq_s_q.ce_n |=> $stable(rw_q))
        else $error("read state moved while idle");

    write_lands_a: assert property (@(posedge clk) disable iff (rst)
        is_wr |=> mem_q[$past(ptr_q)] == $past(seq_s_q.data))
        else $error("write did not land");

    read_push_a: assert property (@(posedge clk) disable iff (rst)
        push |=> rd_valid && buf_q[$past(wp_q)] == $past(mem_q[ptr_q]))
        else $error("read word not buffered");

    stall_full_a: assert property (@(posedge clk) disable iff (rst)
        stall |-> cnt_q == 2'h2)
        else $error("stall with room left");

    buf_bound_a: assert property (@(posedge clk) disable iff (rst)
        cnt_q != 2'h3)
        else $error("read buffer overfilled");

    out_pop_a: assert property (@(posedge clk) disable iff (rst)
        pop |=> seq_data_out == $past(buf_q[rp_q]))
        else $error("popped word not shown");
endmodule

// File: verif/spp_rx_model.sv
// receiver model that takes read words and can stall
module spp_rx_model (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // read word handshake
    input  wire logic rd_valid,
    input  wire logic hold,
    output logic      rd_ready,
    output int        pops
);
    timeunit 1ns;
    timeprecision 1ps;
    assign rd_ready = ~hold;
    always_ff @(posedge clk) begin
        if (rst) pops <= 0;
        else if (rd_valid && rd_ready) pops <= pops + 1;
    end
endmodule

// File: verif/sequential_port_pointer_control_test.sv
// testbench for the sequential port pointer control block
module sequential_port_pointer_control_test
    import spp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    // pin sets {load,jump1,jump2,count,ce,rw,oe}, all active low but rw
    localparam logic [6:0] IDL = 7'h7D, LD = 7'h3D, CNT = 7'h75;
    localparam logic [6:0] J1 = 7'h5D, J2 = 7'h6D, WRC = 7'h71;
    localparam logic [6:0] WR = 7'h79, RD = 7'h7A, RDI = 7'h7E;
    logic clk, rst, stop_at_end, rd_ready, rd_valid, hold;
    logic seq_data_oe, halted, end_of_buffer_flag, stall;
    logic [12:0] pointer;
    logic [15:0] seq_data_out;
    spp_seq_in_t seq_pin;
    spp_cmd_t    cmd_pin;
    int n_errors, samples_checked, pops;
    spp_core DUT (.clk(clk), .rst(rst), .seq_pin(seq_pin),
        .cmd_pin(cmd_pin), .buf1_start(13'h0100), .buf2_start(13'h0200),
        .buf1_end(13'h0120), .buf2_end(13'h0220),
        .stop_at_end(stop_at_end), .seq_data_out(seq_data_out),
        .seq_data_oe(seq_data_oe), .rd_valid(rd_valid),
        .rd_ready(rd_ready), .pointer(pointer), .halted(halted),
        .end_of_buffer_flag(end_of_buffer_flag), .stall(stall));
    spp_rx_model RX (.clk(clk), .rst(rst), .rd_valid(rd_valid),
        .hold(hold), .rd_ready(rd_ready), .pops(pops));
    // ==========================================================
    // access tasks
    task go(input logic [6:0] f, input logic [12:0] a,
            input logic [15:0] d);
        seq_pin <= {f, a, d};
        @(posedge clk);
    endtask
    task idle(input int n);
        repeat (n) go(IDL, 13'h0000, 16'h0000);
    endtask
    task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        samples_checked++;
        if (g !== e) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task rdchk(input logic [12:0] a, input logic [15:0] e);
        int p;
        p = pops;
        go(LD, a, 16'h0000);
        idle(3);
        go(RD, a, 16'h0000);
        for (int i = 0; i < 20 && pops == p; i++) go(RDI, a, 16'h0000);
        if (pops == p) n_errors++;
        repeat (2) go(RDI, a, 16'h0000);
        chk("read word", e, seq_data_out);
    endtask
    task stop_test;
        $display("errors %0d checks %0d", n_errors, samples_checked);
        if (n_errors == 0 && samples_checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // ==========================================================
    // scenarios
    initial begin
        rst <= 1'b1;
        hold <= 1'b0;
        stop_at_end <= 1'b0;
        seq_pin <= {IDL, 13'h0000, 16'h0000};
        cmd_pin <= {3'b111, 3'h0, 16'hFFFF};
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        repeat (4) go(7'h7C, 13'h0000, 16'h0000);
        chk("oe after reset", 16'h0000, {15'h0, seq_data_oe});
        chk("ptr after reset", 16'h0000, {3'h0, pointer});
        go(WRC, 13'h0000, 16'hA000);
        go(WRC, 13'h0000, 16'hA001);
        idle(4);
        chk("ptr after writes", 16'h0002, {3'h0, pointer});
        go(LD, 13'h0010, 16'h0000);
        go(CNT, 13'h0000, 16'h0000);
        idle(4);
        chk("ptr after load", 16'h0010, {3'h0, pointer});
        go(CNT, 13'h0000, 16'h0000);
        idle(4);
        chk("ptr counted", 16'h0011, {3'h0, pointer});
        idle(4);
        chk("ptr held", 16'h0011, {3'h0, pointer});
        go(J1, 13'h0000, 16'h0000);
        go(CNT, 13'h0000, 16'h0000);
        idle(4);
        chk("ptr jump one", 16'h0101, {3'h0, pointer});
        go(J2, 13'h0000, 16'h0000);
        idle(4);
        chk("ptr jump two", 16'h0200, {3'h0, pointer});
        rdchk(13'h0000, 16'hA000);
        rdchk(13'h0001, 16'hA001);
        go(LD, 13'h0030, 16'h0000);
        idle(3);
        go(WR, 13'h0000, 16'hB001);
        go(WR, 13'h0000, 16'hB002);
        idle(3);
        rdchk(13'h0030, 16'hB002);
        chk("oe on read", 16'h0001, {15'h0, seq_data_oe});
        go(7'h78, 13'h0000, 16'hB002);
        repeat (3) go(7'h7C, 13'h0000, 16'h0000);
        chk("oe on write", 16'h0000, {15'h0, seq_data_oe});
        stop_at_end <= 1'b1;
        go(LD, 13'h0120, 16'h0000);
        idle(3);
        go(CNT, 13'h0000, 16'h0000);
        for (int i = 0; i < 20 && halted !== 1'b1; i++) idle(1);
        chk("halt flag", 16'h0001, {15'h0, end_of_buffer_flag});
        cmd_pin <= {3'b010, 3'h4, 16'h0000};
        stop_at_end <= 1'b0;
        go(CNT, 13'h0000, 16'h0000);
        go(CNT, 13'h0000, 16'h0000);
        cmd_pin <= {3'b111, 3'h0, 16'hFFFF};
        for (int i = 0; i < 20 && halted !== 1'b0; i++)
            go(CNT, 13'h0000, 16'h0000);
        chk("released", 16'h0000, {15'h0, halted});
        chk("flag cleared", 16'h0000, {15'h0, end_of_buffer_flag});
        hold <= 1'b1;
        go(LD, 13'h0000, 16'h0000);
        idle(3);
        repeat (3) go(RD, 13'h0000, 16'h0000);
        repeat (6) go(RDI, 13'h0000, 16'h0000);
        chk("word kept", 16'h0001, {15'h0, rd_valid});
        hold <= 1'b0;
        repeat (10) go(RDI, 13'h0000, 16'h0000);
        chk("drained", 16'h0000, {15'h0, rd_valid});
        stop_test();
    end
endmodule
